// file: common/irq_timer_map.vh
// Offsets, field positions, reset values and vectors for the interrupt and timer block
`ifndef IRQ_TIMER_MAP_VH
`define IRQ_TIMER_MAP_VH
// Register word offsets (byte address = 4 * index)
`define REG_IRQ_CTRL_ZERO 4'h0
`define REG_IRQ_CTRL_ONE 4'h1
`define REG_TIMER_ZERO_CONTROL 4'h2
`define REG_TIMER_ONE_CONTROL 4'h3
`define REG_TIMER_ZERO_PRELOAD 4'h4
`define REG_TIMER_ONE_PRELOAD 4'h5
`define REG_TIMER_ZERO_COUNT 4'h6
`define REG_TIMER_ONE_COUNT 4'h7
`define REG_CORE_STATUS 4'h8
// irq_ctrl_reg_zero fields
`define BIT_GLOBAL_EN 0
`define BIT_EXT_EN 1
`define BIT_T0_EN 2
`define BIT_T1_EN 3
`define BIT_EXT_FLAG 4
`define BIT_T0_FLAG 5
`define BIT_T1_FLAG 6
// irq_ctrl_reg_one fields
`define BIT_RTC_EN 0
`define BIT_MF_EN 1
`define BIT_RTC_FLAG 4
`define BIT_MF_FLAG 5
// Timer control fields
`define BIT_TMR_RUN 4
`define BIT_TMR_EDGE 3
`define BIT_TMR_MODE_HI 7
`define BIT_TMR_MODE_LO 6
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3
// Reset values
`define RST_IRQ_CTRL 8'h00
`define RST_TIMER_CONTROL 8'h00
`define RST_PRELOAD 16'h0000
// Vectors
`define VEC_EXT 12'h004
`define VEC_T0 12'h008
`define VEC_T1 12'h00c
`define VEC_RTC 12'h014
`define VEC_MF 12'h018
// Stack
`define STACK_DEPTH 4'h8
`endif

// file: src/irq_timer_ctrl.v
// Interrupt controller with a timer/event counter (timer 0), a system-clock timer (timer 1) and an Avalon-MM register slave
// Notes on behaviour
// - Timer mode counts system clock; overflow requests the timer vector.
// - Pulse-width mode counts system clock only while input is at active level.
// - External timer input change is seen only on a following timer clock.
// - Counter clock held off during counter read or preload write.
// - Bit 4 of timer control starts and stops the counter.
// - Overflow sets the timer flag; interrupt only when its enable is set.
// - An overflow whose timer flag is still clear raises wake-up from power-down regardless of enables.
// - Enables and flags live in two interrupt control registers.
// - Global enable low blocks service; flags still get set.
// - Accept pushes next program counter and loads the vector.
// - Return-from-interrupt pops the saved program counter.
// - Service clears the global enable, preventing nesting.
// - Requests during blocking are recorded in their flags.
// - No acknowledge while the stack is full.
// - Requests between two second-phase pulses serve on the later pulse.
// - Fixed priority: external, timer 0, timer 1, real-time clock, multi-function.
// - Falling edge on interrupt pin sets external flag; vector 04H.
// - External flag cleared by hardware on service.
// - Timer 0 vectors 08H, timer 1 0CH; flag cleared on service.
// - Real-time clock vectors 14H; flag cleared on service.
// - Multi-function vectors 18H; flag cleared on service.
// - Flag stays set until serviced or cleared by software.
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "irq_timer_map.vh"
`default_nettype none
module irq_timer_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  input wire ext_irq_pin_n,
  input wire timer_pin,
  input wire rtc_tick,
  input wire multifunc_event,
  input wire second_phase_clock,
  input wire fetch_ready,
  input wire [11:0] next_pc,
  input wire reti_exec,
  input wire power_down,
  output reg vector_call,
  output reg [11:0] vector_addr,
  output reg [11:0] push_pc,
  output reg resume_call,
  output reg [11:0] resume_pc,
  output reg stack_full,
  output reg wake_up
);
  reg [7:0] irq_ctrl_reg_zero;
  reg [7:0] irq_ctrl_reg_one;
  reg [7:0] timer_zero_control;
  reg [7:0] timer_one_control;
  reg [15:0] preload [0:1];
  reg [15:0] count [0:1];
  reg [11:0] stack [0:7];
  reg [3:0] sp;
  reg [2:0] ext_sync;
  reg [2:0] tpin_sync;
  reg ext_level;
  reg tpin_level;
  reg tpin_seen;
  reg phase_sync0;
  reg phase_sync1;
  reg phase_prev;
  reg [1:0] ovf;
  reg [1:0] inhibit;
  wire [1:0] run;
  wire [1:0] tick;
  wire [1:0] mode0;
  wire ext_fall;
  wire tpin_act;
  wire phase_rise;
  wire [4:0] pending;
  wire do_accept;
  wire do_return;
  wire wr_hit;
  wire rd_hit;
  wire [3:0] idx;
  wire [1:0] count_rd_hit;
  wire [1:0] preload_wr_hit;
  wire ev_edge;
  wire tpin_now_act;
  reg [11:0] next_vec;
  reg [4:0] svc_clear;
  reg [31:0] next_rdata;
  reg next_err;

  assign idx = avs_address[5:2];
  // Writes land on the answer edge, the one edge at which the master surely still holds its data
  assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_hit = avs_read && avs_waitrequest;
  // Per-timer access strobes, kept outside the loop so each compare stays a plain 4-bit one
  assign count_rd_hit = {rd_hit && idx == `REG_TIMER_ONE_COUNT, rd_hit && idx == `REG_TIMER_ZERO_COUNT};
  assign preload_wr_hit = {wr_hit && idx == `REG_TIMER_ONE_PRELOAD, wr_hit && idx == `REG_TIMER_ZERO_PRELOAD};
  assign mode0 = {timer_zero_control[`BIT_TMR_MODE_HI], timer_zero_control[`BIT_TMR_MODE_LO]};
  assign run = {timer_one_control[`BIT_TMR_RUN], timer_zero_control[`BIT_TMR_RUN]};

  // Pin inputs: three stages, change accepted when stages two and three agree
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync <= 3'h7;
      tpin_sync <= 3'h0;
      ext_level <= 1'b1;
      tpin_level <= 1'b0;
      tpin_seen <= 1'b0;
      phase_sync0 <= 1'b0;
      phase_sync1 <= 1'b0;
      phase_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_irq_pin_n};
      tpin_sync <= {tpin_sync[1:0], timer_pin};
      if (ext_sync[1] == ext_sync[2]) begin
        ext_level <= ext_sync[2];
      end
      if (tpin_sync[1] == tpin_sync[2]) begin
        tpin_level <= tpin_sync[2];
      end
      tpin_seen <= tpin_level;
      phase_sync0 <= second_phase_clock;
      phase_sync1 <= phase_sync0;
      phase_prev <= phase_sync1;
    end
  end

  assign ext_fall = ext_sync[1] == ext_sync[2] && !ext_sync[2] && ext_level;
  // Active level: edge bit low means low pulse is measured
  assign tpin_act = timer_zero_control[`BIT_TMR_EDGE] ? tpin_seen : !tpin_seen;
  assign phase_rise = phase_sync1 && !phase_prev;

  // Event mode counts the active edge of the registered input level
  assign ev_edge = timer_zero_control[`BIT_TMR_EDGE] ? (tpin_seen && !tpin_level) : (!tpin_seen && tpin_level);
  assign tpin_now_act = timer_zero_control[`BIT_TMR_EDGE] ? tpin_level : !tpin_level;
  assign tick[0] = run[0] && !inhibit[0] &&
    ((mode0 == `MODE_TIMER) ||
     (mode0 == `MODE_PULSE && tpin_act) ||
     (mode0 == `MODE_EVENT && ev_edge));
  assign tick[1] = run[1] && !inhibit[1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : tmr
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          count[g] <= `RST_PRELOAD;
          preload[g] <= `RST_PRELOAD;
          ovf[g] <= 1'b0;
          inhibit[g] <= 1'b0;
        end else begin
          // Hold the clock on the cycle after the access strobe; a count may be lost here
          inhibit[g] <= count_rd_hit[g] || preload_wr_hit[g];
          ovf[g] <= 1'b0;
          if (preload_wr_hit[g]) begin
            preload[g] <= avs_writedata[15:0];
          end
          if (preload_wr_hit[g] && !run[g]) begin
            count[g] <= avs_writedata[15:0];
          end else if (tick[g]) begin
            if (count[g] == 16'hffff) begin
              count[g] <= preload[g];
              ovf[g] <= 1'b1;
            end else begin
              count[g] <= count[g] + 16'h0001;
            end
          end
        end
      end
    end
  endgenerate

  // Enabled requests per source, bit 0 the most urgent
  assign pending = {irq_ctrl_reg_one[`BIT_MF_FLAG] & irq_ctrl_reg_one[`BIT_MF_EN],
                    irq_ctrl_reg_one[`BIT_RTC_FLAG] & irq_ctrl_reg_one[`BIT_RTC_EN],
                    irq_ctrl_reg_zero[`BIT_T1_FLAG] & irq_ctrl_reg_zero[`BIT_T1_EN],
                    irq_ctrl_reg_zero[`BIT_T0_FLAG] & irq_ctrl_reg_zero[`BIT_T0_EN],
                    irq_ctrl_reg_zero[`BIT_EXT_FLAG] & irq_ctrl_reg_zero[`BIT_EXT_EN]};
  // Sampled only at a second-phase pulse, so requests in between wait for it
  assign do_accept = phase_rise && fetch_ready && irq_ctrl_reg_zero[`BIT_GLOBAL_EN] &&
    (pending != 5'h00) && (sp != `STACK_DEPTH);
  assign do_return = reti_exec && (sp != 4'h0) && !do_accept;

  // Fixed priority encoder, lowest bit wins
  always @* begin
    next_vec = `VEC_MF;
    svc_clear = 5'h10;
    if (pending[0]) begin
      next_vec = `VEC_EXT;
      svc_clear = 5'h01;
    end else if (pending[1]) begin
      next_vec = `VEC_T0;
      svc_clear = 5'h02;
    end else if (pending[2]) begin
      next_vec = `VEC_T1;
      svc_clear = 5'h04;
    end else if (pending[3]) begin
      next_vec = `VEC_RTC;
      svc_clear = 5'h08;
    end else begin
      next_vec = `VEC_MF;
      svc_clear = 5'h10;
    end
  end

  // Interrupt control registers; hardware set wins over a software clear
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ctrl_reg_zero <= `RST_IRQ_CTRL;
      irq_ctrl_reg_one <= `RST_IRQ_CTRL;
      timer_zero_control <= `RST_TIMER_CONTROL;
      timer_one_control <= `RST_TIMER_CONTROL;
    end else begin
      if (wr_hit && idx == `REG_IRQ_CTRL_ZERO) begin
        irq_ctrl_reg_zero <= avs_writedata[7:0] & 8'h7f;
      end
      if (wr_hit && idx == `REG_IRQ_CTRL_ONE) begin
        irq_ctrl_reg_one <= avs_writedata[7:0] & 8'h33;
      end
      if (wr_hit && idx == `REG_TIMER_ZERO_CONTROL) begin
        timer_zero_control <= avs_writedata[7:0];
      end
      if (wr_hit && idx == `REG_TIMER_ONE_CONTROL) begin
        timer_one_control <= avs_writedata[7:0];
      end
      // Single-shot pulse measurement: run bit drops when the input returns
      if (mode0 == `MODE_PULSE && run[0] && tpin_act && !tpin_now_act) begin
        timer_zero_control[`BIT_TMR_RUN] <= 1'b0;
      end
      if (do_accept) begin
        irq_ctrl_reg_zero[`BIT_GLOBAL_EN] <= 1'b0;
        if (svc_clear[0]) irq_ctrl_reg_zero[`BIT_EXT_FLAG] <= 1'b0;
        if (svc_clear[1]) irq_ctrl_reg_zero[`BIT_T0_FLAG] <= 1'b0;
        if (svc_clear[2]) irq_ctrl_reg_zero[`BIT_T1_FLAG] <= 1'b0;
        if (svc_clear[3]) irq_ctrl_reg_one[`BIT_RTC_FLAG] <= 1'b0;
        if (svc_clear[4]) irq_ctrl_reg_one[`BIT_MF_FLAG] <= 1'b0;
      end
      // Events set flags whatever the enables; flags hold until cleared
      if (ext_fall) irq_ctrl_reg_zero[`BIT_EXT_FLAG] <= 1'b1;
      if (ovf[0]) irq_ctrl_reg_zero[`BIT_T0_FLAG] <= 1'b1;
      if (ovf[1]) irq_ctrl_reg_zero[`BIT_T1_FLAG] <= 1'b1;
      if (rtc_tick) irq_ctrl_reg_one[`BIT_RTC_FLAG] <= 1'b1;
      if (multifunc_event) irq_ctrl_reg_one[`BIT_MF_FLAG] <= 1'b1;
    end
  end

  // Program counter stack and sequencer outputs
  // Pointer runs 0 to 8 so a full stack differs from an empty one
  // Stack entries need no reset: each is written before it is read back
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= 4'h0;
      vector_call <= 1'b0;
      vector_addr <= 12'h000;
      push_pc <= 12'h000;
      resume_call <= 1'b0;
      resume_pc <= 12'h000;
      stack_full <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      vector_call <= do_accept;
      resume_call <= do_return;
      if (do_accept) begin
        stack[sp[2:0]] <= next_pc;
        push_pc <= next_pc;
        vector_addr <= next_vec;
        sp <= sp + 4'h1;
      end else if (do_return) begin
        resume_pc <= stack[sp[2:0] - 3'h1];
        sp <= sp - 4'h1;
      end
      stack_full <= (do_accept ? sp + 4'h1 : (do_return ? sp - 4'h1 : sp)) == `STACK_DEPTH;
      // Wake-up pulses on overflow with no regard to enables
      // A timer whose flag is already set gives no wake-up, so software can mask it before halting
      wake_up <= power_down && ((ovf[0] && !irq_ctrl_reg_zero[`BIT_T0_FLAG]) ||
                                (ovf[1] && !irq_ctrl_reg_zero[`BIT_T1_FLAG]));
    end
  end

  // Avalon slave: one wait cycle, answer on the second cycle
  // Unmapped indexes read as zero and answer with an error
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (idx)
      `REG_IRQ_CTRL_ZERO: next_rdata = {24'h000000, irq_ctrl_reg_zero};
      `REG_IRQ_CTRL_ONE: next_rdata = {24'h000000, irq_ctrl_reg_one};
      `REG_TIMER_ZERO_CONTROL: next_rdata = {24'h000000, timer_zero_control};
      `REG_TIMER_ONE_CONTROL: next_rdata = {24'h000000, timer_one_control};
      `REG_TIMER_ZERO_PRELOAD: next_rdata = {16'h0000, preload[0]};
      `REG_TIMER_ONE_PRELOAD: next_rdata = {16'h0000, preload[1]};
      `REG_TIMER_ZERO_COUNT: next_rdata = {16'h0000, count[0]};
      `REG_TIMER_ONE_COUNT: next_rdata = {16'h0000, count[1]};
      `REG_CORE_STATUS: next_rdata = {27'h0000000, stack_full, sp};
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? next_rdata : 32'h0000_0000;
        avs_response <= next_err ? 2'h3 : 2'h0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
endmodule // irq_timer_ctrl
`default_nettype wire

// file: tb/irq_timer_monitor.sv
// Port-level checks of the interrupt and timer block
`timescale 1ns/1ps
`default_nettype none
module irq_timer_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic fetch_ready,
  input wire logic [11:0] next_pc,
  input wire logic reti_exec,
  input wire logic power_down,
  input wire logic vector_call,
  input wire logic [11:0] vector_addr,
  input wire logic [11:0] push_pc,
  input wire logic resume_call,
  input wire logic stack_full,
  input wire logic wake_up
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_UNMAPPED: assert property (!avs_waitrequest && avs_address[5:2] > 4'h8 |-> avs_response == 2'h3)
    else $error("unmapped access not refused");
  AST_NO_NEST: assert property (vector_call |=> !vector_call [*2])
    else $error("back to back vector calls");
  AST_VECTOR: assert property (vector_call |-> vector_addr inside {12'h004, 12'h008, 12'h00c, 12'h014, 12'h018})
    else $error("illegal vector");
  AST_PUSH: assert property (vector_call |-> push_pc == $past(next_pc) && $past(fetch_ready))
    else $error("wrong pushed address");
  AST_FULL: assert property (stack_full |=> !vector_call)
    else $error("call with full stack");
  AST_RESUME: assert property (resume_call |-> $past(reti_exec))
    else $error("resume without return");
  AST_WAKE: assert property (wake_up |-> power_down || $past(power_down))
    else $error("wake outside power down");
endmodule // irq_timer_monitor
bind irq_timer_ctrl irq_timer_monitor irq_timer_monitor_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .fetch_ready(fetch_ready), .next_pc(next_pc), .reti_exec(reti_exec),
  .power_down(power_down), .vector_call(vector_call), .vector_addr(vector_addr), .push_pc(push_pc),
  .resume_call(resume_call), .stack_full(stack_full), .wake_up(wake_up));
`default_nettype wire

// file: tb/core_model.sv
// Program sequencer stand-in: phase clock, fetch slots, moving program counter
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic mclk,
  input wire logic rst_n,
  output var logic second_phase_clock,
  output var logic fetch_ready,
  output var logic [11:0] next_pc
);
  logic [1:0] ph;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 2'h0;
      second_phase_clock <= 1'b0;
      fetch_ready <= 1'b0;
      next_pc <= 12'h020;
    end else begin
      ph <= ph + 2'h1;
      second_phase_clock <= ph[1];
      fetch_ready <= (ph != 2'h3);
      next_pc <= next_pc + 12'h001;
    end
  end
endmodule // core_model
`default_nettype wire

// file: tb/tb_irq_timer_ctrl.sv
// Self-checking bench for the interrupt and timer block
`timescale 1ns/1ps
`include "irq_timer_map.vh"
`default_nettype none
module tb_irq_timer_ctrl;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic ext_irq_pin_n = 1'b1, timer_pin = 1'b0, rtc_tick = 1'b0, multifunc_event = 1'b0;
  logic reti_exec = 1'b0, power_down = 1'b0;
  logic [31:0] avs_readdata, rd, v;
  logic [1:0] avs_response, rs;
  logic avs_waitrequest, second_phase_clock, fetch_ready, vector_call, resume_call, stack_full, wake_up;
  logic [11:0] next_pc, vector_addr, push_pc, resume_pc;
  logic [11:0] vec [5] = '{`VEC_EXT, `VEC_T0, `VEC_T1, `VEC_RTC, `VEC_MF};
  logic [11:0] q [$];
  int n_fail = 0, checks = 0, calls = 0, wakes = 0, i;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (vector_call === 1'b1) calls++;
    if (wake_up === 1'b1) wakes++;
  end
  irq_timer_ctrl irq_timer_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .ext_irq_pin_n(ext_irq_pin_n), .timer_pin(timer_pin), .rtc_tick(rtc_tick), .multifunc_event(multifunc_event),
    .second_phase_clock(second_phase_clock), .fetch_ready(fetch_ready), .next_pc(next_pc), .reti_exec(reti_exec),
    .power_down(power_down), .vector_call(vector_call), .vector_addr(vector_addr), .push_pc(push_pc),
    .resume_call(resume_call), .resume_pc(resume_pc), .stack_full(stack_full), .wake_up(wake_up));
  core_model core_model_inst (.mclk(mclk), .rst_n(rst_n), .second_phase_clock(second_phase_clock),
    .fetch_ready(fetch_ready), .next_pc(next_pc));
  task automatic give_verdict();
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low, then spends one edge so the next call starts clean
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      $display("[ERR] %0t bus answer timed out", $time);
      n_fail++;
      give_verdict();
    end
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic await(input logic res);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((res ? resume_call : vector_call) !== 1'b1 && n < 300);
    if ((res ? resume_call : vector_call) !== 1'b1) begin
      $display("[ERR] %0t call or return timed out", $time);
      n_fail++;
      give_verdict();
    end
  endtask
  initial begin
    v = $urandom(58);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 6; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b0, 4'hf, 32'h0);
    chk(rs, 2'h3);
    repeat (3) begin
      v = $urandom & 32'h0e;
      bus(1'b1, `REG_IRQ_CTRL_ZERO, v);
      bus(1'b0, `REG_IRQ_CTRL_ZERO, 32'h0);
      chk(rd, v);
    end
    bus(1'b1, `REG_IRQ_CTRL_ZERO, 32'h02);
    ext_irq_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    ext_irq_pin_n <= 1'b1;
    repeat (20) @(posedge mclk);
    bus(1'b0, `REG_IRQ_CTRL_ZERO, 32'h0);
    chk(rd, 32'h12);
    chk(calls, 0);
    // Timers overflow while halted with every timer enable off
    power_down <= 1'b1;
    bus(1'b1, `REG_TIMER_ZERO_PRELOAD, 32'hfff0);
    bus(1'b1, `REG_TIMER_ONE_PRELOAD, 32'hfff0);
    bus(1'b1, `REG_TIMER_ZERO_CONTROL, 32'h80);
    bus(1'b1, `REG_TIMER_ONE_CONTROL, 32'h80);
    bus(1'b1, `REG_TIMER_ZERO_CONTROL, 32'h90);
    bus(1'b1, `REG_TIMER_ONE_CONTROL, 32'h90);
    repeat (40) @(posedge mclk);
    bus(1'b1, `REG_TIMER_ZERO_CONTROL, 32'h80);
    bus(1'b1, `REG_TIMER_ONE_CONTROL, 32'h80);
    power_down <= 1'b0;
    chk(wakes > 0, 1);
    bus(1'b0, `REG_IRQ_CTRL_ZERO, 32'h0);
    chk(rd[6:4], 3'h7);
    // Timer flag already set before halting: a new overflow must not wake
    v = wakes;
    power_down <= 1'b1;
    bus(1'b1, `REG_TIMER_ZERO_CONTROL, 32'h90);
    repeat (40) @(posedge mclk);
    bus(1'b1, `REG_TIMER_ZERO_CONTROL, 32'h80);
    power_down <= 1'b0;
    chk(wakes, v);
    rtc_tick <= 1'b1;
    multifunc_event <= 1'b1;
    @(posedge mclk);
    rtc_tick <= 1'b0;
    multifunc_event <= 1'b0;
    bus(1'b1, `REG_IRQ_CTRL_ONE, 32'h33);
    chk(calls, 0);
    bus(1'b1, `REG_IRQ_CTRL_ZERO, 32'h7f);
    foreach (vec[k]) begin
      await(1'b0);
      chk(vector_addr, vec[k]);
      q.push_back(push_pc);
      bus(1'b0, `REG_IRQ_CTRL_ZERO, 32'h0);
      chk(rd[0], 1'b0);
      bus(1'b1, `REG_IRQ_CTRL_ZERO, rd | 32'h1);
    end
    bus(1'b0, `REG_IRQ_CTRL_ZERO, 32'h0);
    chk(rd[6:4], 3'h0);
    bus(1'b0, `REG_IRQ_CTRL_ONE, 32'h0);
    chk(rd[5:4], 2'h0);
    while (q.size() > 0) begin
      reti_exec <= 1'b1;
      @(posedge mclk);
      reti_exec <= 1'b0;
      await(1'b1);
      chk(resume_pc, q.pop_back());
    end
    // Eight calls fill the stack; a ninth request must wait for a return
    for (i = 0; i < 9; i++) begin
      rtc_tick <= 1'b1;
      @(posedge mclk);
      rtc_tick <= 1'b0;
      if (i < 8) begin
        await(1'b0);
        chk(vector_addr, `VEC_RTC);
        q.push_back(push_pc);
      end
      bus(1'b1, `REG_IRQ_CTRL_ZERO, 32'h0f);
    end
    repeat (20) @(posedge mclk);
    chk(calls, 13);
    chk(stack_full, 1'b1);
    bus(1'b0, `REG_CORE_STATUS, 32'h0);
    chk(rd, 32'h18);
    reti_exec <= 1'b1;
    @(posedge mclk);
    reti_exec <= 1'b0;
    await(1'b1);
    chk(resume_pc, q.pop_back());
    await(1'b0);
    chk(vector_addr, `VEC_RTC);
    give_verdict();
  end
endmodule // tb_irq_timer_ctrl
`default_nettype wire
